// >>> pkg/btag_cfg.svh
`ifndef BTAG_CFG_SVH
`define BTAG_CFG_SVH

// Program counter value after reset
`define BTAG_PC_RESET 16'h0000
// Vector table window, low byte at the even address
`define BTAG_VEC_BASE 16'h0040
`define BTAG_VEC_LAST 16'h007f
// Index field position in the instruction code
`define BTAG_IDX_LSB 1
`define BTAG_IDX_MSB 5
// Sign bit of the displacement
`define BTAG_DISP_SIGN 7
// Vector table depth in entries
`define BTAG_VEC_DEPTH 32

`endif

// >>> pkg/btag_pkg.sv
package btag_pkg;

    typedef enum logic [2:0] {
        BTAG_OP_SEQ = 3'h0,
        BTAG_OP_REL = 3'h1,
        BTAG_OP_ABS = 3'h2,
        BTAG_OP_TBL = 3'h3,
        BTAG_OP_REG = 3'h4
    } btag_op_e;

    // One decoded instruction as handed over by the decoder
    typedef struct packed {
        logic valid;
        btag_op_e op;
        logic [2:0] length;
        logic [7:0] code;
        logic [7:0] branch_displacement;
        logic [15:0] absolute_target_field;
    } btag_req_s;

    // Write port into the vector table image
    typedef struct packed {
        logic en;
        logic [4:0] index;
        logic [15:0] target;
    } btag_vwr_s;

    typedef enum logic [1:0] {
        BTAG_ST_RUN = 2'b00,
        BTAG_ST_TBL = 2'b01
    } btag_st_e;

endpackage

// >>> hw/btag_vec_mem.sv
`timescale 1ns/1ps
`include "btag_cfg.svh"

module btag_vec_mem
    import btag_pkg::*;
(
    input wire logic clk,
    input wire btag_vwr_s wr,
    input wire logic [4:0] rd_index,
    output logic [15:0] rd_data
);

    logic [15:0] mem_q [`BTAG_VEC_DEPTH];
    logic [15:0] rd_data_q;

    // Table contents are data, not control, so they carry no reset
    always_ff @(posedge clk) begin
        if (wr.en) begin
            mem_q[wr.index] <= wr.target;
        end
        rd_data_q <= mem_q[rd_index];
    end

    assign rd_data = rd_data_q;

endmodule // btag_vec_mem

// >>> hw/btag_core.sv
`timescale 1ns/1ps
`include "btag_cfg.svh"


module btag_core
    import btag_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire btag_req_s req,
    input wire logic branch_taken,
    input wire logic [15:0] accumulator_pair,
    input wire btag_vwr_s vec_wr,
    output logic [15:0] program_counter,
    output logic [15:0] operand_address,
    output logic [15:0] vector_address,
    output logic busy,
    output logic pc_loaded
);

    // ********************************************
    // Helpers
    // ********************************************
    function automatic logic [15:0] sext8(input logic [7:0] v);
        sext8 = {{8{v[`BTAG_DISP_SIGN]}}, v};
    endfunction

    function automatic logic [15:0] add16(input logic [15:0] a,
                                          input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        add16 = s[15:0];
    endfunction

    // Entry index n sits at 40H + 2n, low byte at the even address
    function automatic logic [15:0] vec_entry_addr(input logic [4:0] n);
        vec_entry_addr = add16(`BTAG_VEC_BASE, {10'h000, n, 1'b0});
    endfunction

    // ********************************************
    // State
    // ********************************************
    btag_st_e st_q, st_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] opa_q, opa_d;
    logic [15:0] vaddr_q, vaddr_d;
    logic busy_q, busy_d;
    logic load_q, load_d;

    // Request decode and table read data
    logic [4:0] idx;
    logic [15:0] next_pc;
    logic [15:0] vec_data;
    logic take;
    logic tbl_start;

    assign idx = req.code[`BTAG_IDX_MSB:`BTAG_IDX_LSB];
    assign next_pc = add16(pc_q, {13'h0000, req.length});
    // A request counts only while no table read is pending
    assign take = req.valid && (st_q == BTAG_ST_RUN);
    assign tbl_start = take && (req.op == BTAG_OP_TBL);

    btag_vec_mem i_btag_vec_mem (
        .clk(clk),
        .wr(vec_wr),
        .rd_index(idx),
        .rd_data(vec_data)
    );

    // ********************************************
    // Sequencer
    // ********************************************
    always_comb begin
        st_d = st_q;
        busy_d = 1'b0;
        unique case (st_q)
            BTAG_ST_RUN: begin
                if (tbl_start) begin
                    // Table read costs one cycle; decoder holds off meanwhile
                    st_d = BTAG_ST_TBL;
                    busy_d = 1'b1;
                end
            end
            BTAG_ST_TBL: begin
                // A request seen here is dropped; the decoder must wait
                st_d = BTAG_ST_RUN;
            end
            default: begin
                // Unused state codes fall back to the run state
                st_d = BTAG_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= BTAG_ST_RUN;
            busy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            busy_q <= busy_d;
        end
    end

    // ********************************************
    // Program counter
    // ********************************************
    always_comb begin
        pc_d = pc_q;
        load_d = 1'b0;
        if (st_q == BTAG_ST_TBL) begin
            // Entry was read on the edge that took the table call
            pc_d = vec_data;
            load_d = 1'b1;
        end else if (take) begin
            unique case (req.op)
                BTAG_OP_SEQ: begin
                    pc_d = next_pc;
                end
                BTAG_OP_REL: begin
                    // Not taken falls through to the next instruction
                    pc_d = next_pc;
                    if (branch_taken) begin
                        // Adds to the following instruction start
                        pc_d = add16(next_pc,
                            sext8(req.branch_displacement));
                        load_d = 1'b1;
                    end
                end
                BTAG_OP_ABS: begin
                    pc_d = req.absolute_target_field;
                    load_d = 1'b1;
                end
                BTAG_OP_TBL: begin
                    // Stepped value shows for one cycle until the entry lands
                    pc_d = next_pc;
                end
                BTAG_OP_REG: begin
                    pc_d = accumulator_pair;
                    load_d = 1'b1;
                end
                default: begin
                    // Undefined operation codes act as plain steps
                    pc_d = next_pc;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pc_q <= `BTAG_PC_RESET;
            load_q <= 1'b0;
        end else begin
            pc_q <= pc_d;
            load_q <= load_d;
        end
    end

    // ********************************************
    // Operand address
    // ********************************************
    always_comb begin
        // Every taken request refreshes it, branch or not
        opa_d = opa_q;
        if (take) begin
            opa_d = req.absolute_target_field;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            opa_q <= 16'h0000;
        end else begin
            opa_q <= opa_d;
        end
    end

    // ********************************************
    // Vector table address
    // ********************************************
    always_comb begin
        // Held after the call so the fetch path may read it back
        vaddr_d = vaddr_q;
        if (tbl_start) begin
            vaddr_d = vec_entry_addr(idx);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            vaddr_q <= 16'h0000;
        end else begin
            vaddr_q <= vaddr_d;
        end
    end

    // ********************************************
    // Outputs
    // ********************************************
    // Outputs are registers, so downstream logic sees no decode glitches
    assign program_counter = pc_q;
    assign operand_address = opa_q;
    assign vector_address = vaddr_q;
    assign busy = busy_q;
    assign pc_loaded = load_q;

endmodule // btag_core

// >>> verif/btag_core_sva.sv
`timescale 1ns/1ps
module btag_core_sva
    import btag_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire btag_req_s req,
    input wire logic branch_taken,
    input wire logic [15:0] accumulator_pair,
    input wire logic [15:0] program_counter,
    input wire logic [15:0] operand_address,
    input wire logic [15:0] vector_address,
    input wire logic busy,
    input wire logic pc_loaded
);
    // *****
    // Checks
    // *****
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire t = req.valid && !busy;
    wire [2:0] o = req.op;
    wire [7:0] b = req.branch_displacement;
    wire [15:0] f = req.absolute_target_field;
    wire [15:0] ctr = program_counter;
    wire [15:0] nx = ctr + 16'(req.length);
    wire [15:0] rl = nx + {{8{b[7]}}, b};
    wire [15:0] va = 16'h0040 + {10'h000, req.code[5:1], 1'b0};
    property p_seq;
        t && o == BTAG_OP_SEQ |=> ctr == $past(nx) && !pc_loaded;
    endproperty
    a_seq: assert property (p_seq) else $error("seq step");
    property p_rel;
        t && o == BTAG_OP_REL && branch_taken
            |=> ctr == $past(rl) && pc_loaded;
    endproperty
    a_rel: assert property (p_rel) else $error("rel target");
    property p_abs; t && o == BTAG_OP_ABS |=> ctr == $past(f); endproperty
    a_abs: assert property (p_abs) else $error("abs target");
    property p_reg;
        t && o == BTAG_OP_REG |=> ctr == $past(accumulator_pair);
    endproperty
    a_reg: assert property (p_reg) else $error("reg target");
    property p_vad; t && o == BTAG_OP_TBL |=> vector_address == $past(va);
    endproperty
    a_vad: assert property (p_vad) else $error("vec addr");
    property p_tbl; t && o == BTAG_OP_TBL |=> busy && !pc_loaded ##1 pc_loaded;
    endproperty
    a_tbl: assert property (p_tbl) else $error("tbl timing");
    property p_opa; t |=> operand_address == $past(f); endproperty
    a_opa: assert property (p_opa) else $error("oper addr");
    property p_bsy; busy |=> !busy; endproperty
    a_bsy: assert property (p_bsy) else $error("busy long");
    c_rel: cover property (t && o == BTAG_OP_REL && branch_taken);
    c_tbl: cover property (t && o == BTAG_OP_TBL);
    c_reg: cover property (t && o == BTAG_OP_REG);
endmodule // btag_core_sva

bind btag_core btag_core_sva i_sva(.clk, .reset, .req, .branch_taken,
    .accumulator_pair, .program_counter, .operand_address,
    .vector_address, .busy, .pc_loaded);

// >>> verif/btag_dec_model.sv
`timescale 1ns/1ps
module btag_dec_model
    import btag_pkg::*;
(
    input wire logic clk,
    output btag_req_s req,
    output btag_vwr_s vec_wr
);
    // *****
    // Decoder side: one strobe, then an idle cycle
    // *****
    initial begin
        req = '0;
        vec_wr = '0;
    end
    task automatic issue(input btag_op_e op, input logic [2:0] len,
        input logic [7:0] code, input logic [15:0] fld);
        @(posedge clk);
        req <= '{1'b1, op, len, code, fld[7:0], fld};
        @(posedge clk);
        req.valid <= 1'b0;
    endtask
    task automatic load(input logic [4:0] idx, input logic [15:0] val);
        @(posedge clk);
        vec_wr <= '{1'b1, idx, val};
        @(posedge clk);
        vec_wr.en <= 1'b0;
    endtask
endmodule // btag_dec_model

// >>> verif/branch_target_address_generator_test.sv
`timescale 1ns/1ps
module branch_target_address_generator_test
    import btag_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic branch_taken = 1'b0;
    logic [15:0] accumulator_pair = '0;
    btag_req_s req;
    btag_vwr_s vec_wr;
    logic [15:0] program_counter, operand_address, vector_address;
    logic busy, pc_loaded;
    int mismatches = 0;
    int total_checks = 0;
    always #4 clk = ~clk;
    btag_dec_model i_btag_dec_model(.clk(clk), .req(req), .vec_wr(vec_wr));
    btag_core i_btag_core(.clk(clk), .reset(reset), .req(req),
        .branch_taken(branch_taken), .accumulator_pair(accumulator_pair),
        .vec_wr(vec_wr), .program_counter(program_counter),
        .operand_address(operand_address),
        .vector_address(vector_address), .busy(busy), .pc_loaded(pc_loaded));
    // *****
    // Scenarios
    // *****
    task automatic chk(input string w, input logic [15:0] e,
        input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s exp %h got %h", w, e, g);
        end
    endtask
    task automatic go(input btag_op_e op, input logic [2:0] len,
        input logic [15:0] fld, input logic [15:0] e);
        i_btag_dec_model.issue(op, len, 8'h00, fld);
        #1;
        chk("pc", e, program_counter);
    endtask
    task automatic t_seq();
        #1;
        chk("pc", 16'h0000, program_counter);
        chk("oper", 16'h0000, operand_address);
        chk("vec", 16'h0000, vector_address);
        go(BTAG_OP_SEQ, 3'h3, 16'h0000, 16'h0003);
        go(BTAG_OP_SEQ, 3'h1, 16'h0000, 16'h0004);
    endtask
    task automatic t_rel();
        @(posedge clk);
        branch_taken <= 1'b1;
        go(BTAG_OP_REL, 3'h2, 16'h00fe, 16'h0004);
        chk("load", 16'h0001, {15'h0000, pc_loaded});
        go(BTAG_OP_REL, 3'h2, 16'h0080, 16'hff86);
        go(BTAG_OP_REL, 3'h2, 16'h007f, 16'h0007);
        @(posedge clk);
        branch_taken <= 1'b0;
        go(BTAG_OP_REL, 3'h3, 16'h0070, 16'h000a);
        chk("load", 16'h0000, {15'h0000, pc_loaded});
    endtask
    task automatic t_abs_reg();
        go(BTAG_OP_ABS, 3'h3, 16'hfe00, 16'hfe00);
        chk("load", 16'h0001, {15'h0000, pc_loaded});
        chk("oper", 16'hfe00, operand_address);
        @(posedge clk);
        accumulator_pair <= 16'hbeef;
        go(BTAG_OP_REG, 3'h1, 16'h0000, 16'hbeef);
    endtask
    task automatic t_tbl();
        i_btag_dec_model.load(5'h1f, 16'h5a5a);
        i_btag_dec_model.issue(BTAG_OP_TBL, 3'h1, 8'h3e, 16'h0000);
        #1;
        chk("vec", 16'h007e, vector_address);
        chk("busy", 16'h0001, {15'h0000, busy});
        @(posedge clk);
        #1;
        chk("pc", 16'h5a5a, program_counter);
        chk("load", 16'h0001, {15'h0000, pc_loaded});
        chk("busy", 16'h0000, {15'h0000, busy});
        go(btag_op_e'(3'h5), 3'h2, 16'h0000, 16'h5a5c);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_seq();
        t_rel();
        t_abs_reg();
        t_tbl();
        stop_test();
    end
    initial begin
        #5000;
        mismatches++;
        stop_test();
    end
endmodule // branch_target_address_generator_test
